// File: src/hbd_host_port.sv
// How it works
// - Async ready is open drain, released on the crystal clock.
// - Async ready held low for wait states while zero-wait is off.
// - Async data read waits while the read FIFO holds under 4 bytes.
// - Async data write waits while the write FIFO is full.
// - In VL mode sync ready idles high, falls to mark completion.
// - Sync ready only changes on local bus clock edges.
// - Burst mode samples ready-return on falling local clock edges.
// - Burst mode holds synchronous cycles until ready-return sampled high.
// - Interrupt output goes high on a status event.
// - No interrupt line selection exists; the interrupt output is one fixed line.
// - Local device hit low when qualifier low and address matches base.
// - Local device hit is combinational from raw address and qualifier.
// - Data path select grants data access regardless of address decode.
// - Data path accesses move 32 bits each cycle.
// - Mode select low picks VL, high picks burst mode for sync cycles.
// - Address decode only enabled while the qualifier is low.
// - Byte lanes ignored under data path select; full 32 bits assumed.
// - Direction high means write, low means read for sync cycles.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Flip-flop FIFO with valid/ready on both sides
// ----------------------------------------------------------------------------
module hbd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    wire              push;
    wire              pop;

    assign o_in_ready  = (count_reg != CNT_FULL);
    assign o_out_valid = (count_reg != '0);
    assign o_out_data  = mem_reg[rd_ptr_reg];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            count_reg <= count_next;
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Storage carries no reset; only the pointers and the count must be defined
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

endmodule : hbd_fifo

// ----------------------------------------------------------------------------
// Host bus handshake, ready generation and local device decode
// ----------------------------------------------------------------------------
module hbd_host_port #(
    parameter int DEPTH = 4
) (
    input  wire logic                           i_clock,
    input  wire logic                           i_rst,
    input  wire logic                           i_local_bus_clock,
    input  wire logic                           i_read_strobe_n,
    input  wire logic                           i_write_strobe_n,
    input  wire logic                           i_data_path_select_n,
    input  wire logic                           i_address_qualifier,
    input  wire logic                           i_vl_mode_select_n,
    input  wire logic                           i_write_not_read,
    input  wire logic                           i_ready_return_n,
    input  wire logic [3:0]                     i_byte_lane_enable_n,
    input  wire logic [hbd_pkg::ADDR_WIDTH-1:0] i_upper_address_lines,
    input  wire logic [hbd_pkg::DATA_WIDTH-1:0] i_data,
    output logic      [hbd_pkg::DATA_WIDTH-1:0] o_data,
    output logic                                o_data_oe,
    output logic                                o_async_ready_od_o,
    output logic                                o_async_ready_od_oe,
    output logic                                o_sync_ready_n,
    output logic                                o_local_device_hit_n,
    output logic                                o_host_interrupt,
    output logic      [3:0]                     o_lane_select,
    input  wire logic [hbd_pkg::BASE_WIDTH-1:0] i_base_high,
    input  wire logic                           i_zero_wait,
    input  wire logic                           i_status_pending,
    input  wire logic [hbd_pkg::DATA_WIDTH-1:0] i_rx_data,
    input  wire logic                           i_rx_valid,
    output logic                                o_rx_ready,
    output logic      [hbd_pkg::DATA_WIDTH-1:0] o_tx_data,
    output logic                                o_tx_valid,
    input  wire logic                           i_tx_ready
);
    import hbd_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------------
    hbd_pins_type              pins_raw;
    hbd_pins_type              pins_meta_reg;
    hbd_pins_type              pins_reg;
    logic                      local_bus_clock_prev_reg;
    wire                       local_bus_clock_rise;
    wire                       local_bus_clock_fall;

    assign pins_raw = '{
        local_bus_clock  : i_local_bus_clock,
        rd_n  : i_read_strobe_n,
        wr_n  : i_write_strobe_n,
        dps_n : i_data_path_select_n,
        aq    : i_address_qualifier,
        vl_n  : i_vl_mode_select_n,
        wnr   : i_write_not_read,
        rtn_n : i_ready_return_n,
        be_n  : i_byte_lane_enable_n,
        addr  : i_upper_address_lines,
        data  : i_data
    };

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pins_meta_reg <= PINS_RESET;
            pins_reg      <= PINS_RESET;
            local_bus_clock_prev_reg <= 1'b1;
        end else begin
            pins_meta_reg <= pins_raw;
            pins_reg      <= pins_meta_reg;
            local_bus_clock_prev_reg <= pins_reg.local_bus_clock;
        end
    end

    // A parked-high local clock gives no edges, so the sync engine keeps its current state
    assign local_bus_clock_rise = pins_reg.local_bus_clock & ~local_bus_clock_prev_reg;
    assign local_bus_clock_fall = ~pins_reg.local_bus_clock & local_bus_clock_prev_reg;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire [ADDR_WIDTH-1:0] base_match;
    wire                  raw_hit;
    wire                  reg_hit;
    wire                  data_sel;
    wire                  burst_mode;

    assign base_match = {i_base_high, BASE_LOW_NIBBLE};
    // Bypasses the synchroniser on purpose: the host needs this decode early
    assign raw_hit              = ~i_address_qualifier & (i_upper_address_lines == base_match);
    assign o_local_device_hit_n = ~raw_hit;
    assign reg_hit              = ~pins_reg.aq & (pins_reg.addr == base_match);
    assign data_sel             = ~pins_reg.dps_n;
    assign burst_mode           = pins_reg.vl_n;

    // ------------------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------------------
    wire [DATA_WIDTH-1:0] rd_fifo_data;
    wire                  rd_fifo_valid;
    wire                  wr_fifo_ready;
    wire                  rd_pop;
    wire                  wr_push;

    hbd_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (DEPTH)
    ) u_read_fifo (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_in_data   (i_rx_data),
        .i_in_valid  (i_rx_valid),
        .o_in_ready  (o_rx_ready),
        .o_out_data  (rd_fifo_data),
        .o_out_valid (rd_fifo_valid),
        .i_out_ready (rd_pop)
    );

    hbd_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (DEPTH)
    ) u_write_fifo (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_in_data   (pins_reg.data),
        .i_in_valid  (wr_push),
        .o_in_ready  (wr_fifo_ready),
        .o_out_data  (o_tx_data),
        .o_out_valid (o_tx_valid),
        .i_out_ready (i_tx_ready)
    );

    // ------------------------------------------------------------------------
    // Asynchronous cycle engine
    // ------------------------------------------------------------------------
    hbd_async_state_type       a_state_reg;
    hbd_sync_state_type        s_state_reg;
    logic [WAIT_CNT_WIDTH-1:0] wait_cnt_reg;
    logic                      a_read_reg;
    logic                      a_data_reg;
    wire                       strobe_active;
    wire                       async_start;
    wire                       sync_start;
    wire                       wait_done;
    wire                       async_fifo_ok;
    wire                       async_go;
    wire                       async_xfer;

    assign strobe_active = ~pins_reg.rd_n | ~pins_reg.wr_n;
    assign sync_start    = (s_state_reg == S_IDLE) & (a_state_reg == A_IDLE) & local_bus_clock_rise & data_sel;
    assign async_start   = (a_state_reg == A_IDLE) & (s_state_reg == S_IDLE) & ~sync_start &
                           strobe_active & (data_sel | reg_hit);
    assign wait_done     = i_zero_wait | (wait_cnt_reg == WAIT_CNT_LAST);
    // One 32-bit word is exactly 4 bytes, so "under 4 bytes" means empty
    assign async_fifo_ok = ~a_data_reg | (a_read_reg ? rd_fifo_valid : wr_fifo_ready);
    assign async_go      = (a_state_reg == A_HOLD) & wait_done & async_fifo_ok;
    assign async_xfer    = async_go & a_data_reg;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            a_state_reg  <= A_IDLE;
            wait_cnt_reg <= '0;
            a_read_reg   <= 1'b0;
            a_data_reg   <= 1'b0;
        end else begin
            case (a_state_reg)
                A_IDLE: begin
                    wait_cnt_reg <= '0;
                    if (async_start) begin
                        a_read_reg  <= ~pins_reg.rd_n;
                        a_data_reg  <= data_sel;
                        a_state_reg <= A_HOLD;
                    end
                end
                A_HOLD: begin
                    if (!wait_done) begin
                        wait_cnt_reg <= wait_cnt_reg + 1'b1;
                    end
                    if (async_go) begin
                        a_state_reg <= A_DONE;
                    end
                end
                A_DONE: begin
                    if (!strobe_active) begin
                        a_state_reg <= A_IDLE;
                    end
                end
                default: begin
                    a_state_reg <= A_IDLE;
                end
            endcase
        end
    end

    // Open drain: only ever pulls low; release timing follows the crystal clock
    assign o_async_ready_od_o  = 1'b0;
    assign o_async_ready_od_oe = (a_state_reg == A_HOLD) & ~async_go;

    // ------------------------------------------------------------------------
    // Synchronous cycle engine
    // ------------------------------------------------------------------------
    logic s_write_reg;
    logic sync_ready_n_reg;
    wire  rtn_ok;
    wire  sync_fifo_ok;
    wire  sync_xfer;

    // Ready-return is only looked at on the falling local clock edge
    assign rtn_ok       = ~burst_mode | pins_reg.rtn_n;
    assign sync_fifo_ok = s_write_reg ? wr_fifo_ready : rd_fifo_valid;
    assign sync_xfer    = (s_state_reg == S_ACCESS) & local_bus_clock_fall & rtn_ok & sync_fifo_ok;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_state_reg      <= S_IDLE;
            s_write_reg      <= 1'b0;
            sync_ready_n_reg <= 1'b1;
        end else begin
            case (s_state_reg)
                S_IDLE: begin
                    if (sync_start) begin
                        s_write_reg <= pins_reg.wnr;
                        s_state_reg <= S_ACCESS;
                    end
                end
                S_ACCESS: begin
                    if (sync_xfer) begin
                        if (!burst_mode) begin
                            sync_ready_n_reg <= 1'b0;
                            s_state_reg      <= S_DONE;
                        end else begin
                            s_state_reg <= S_IDLE;
                        end
                    end
                end
                S_DONE: begin
                    if (local_bus_clock_fall) begin
                        sync_ready_n_reg <= 1'b1;
                        s_state_reg      <= S_IDLE;
                    end
                end
                default: begin
                    s_state_reg <= S_IDLE;
                end
            endcase
        end
    end

    assign o_sync_ready_n = sync_ready_n_reg;

    // ------------------------------------------------------------------------
    // Data movement
    // ------------------------------------------------------------------------
    logic [DATA_WIDTH-1:0] data_out_reg;
    logic [3:0]            lane_reg;
    logic                  interrupt_reg;
    wire  [3:0]            lane_next;

    // The two engines never run together, so their transfers cannot collide
    assign wr_push   = (async_xfer & ~a_read_reg) | (sync_xfer & s_write_reg);
    assign rd_pop    = (async_xfer & a_read_reg) | (sync_xfer & ~s_write_reg);
    assign lane_next = data_sel ? FULL_LANES : ~pins_reg.be_n;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            data_out_reg  <= '0;
            lane_reg      <= NO_LANES;
            interrupt_reg <= 1'b0;
        end else begin
            if (rd_pop) begin
                data_out_reg <= rd_fifo_data;
            end
            if (async_start | sync_start) begin
                lane_reg <= lane_next;
            end
            // Single fixed interrupt line, no routing choice
            interrupt_reg <= i_status_pending;
        end
    end

    assign o_data           = data_out_reg;
    assign o_data_oe        = ((a_state_reg != A_IDLE) & a_read_reg & ~pins_reg.rd_n) |
                              ((s_state_reg != S_IDLE) & ~s_write_reg);
    assign o_lane_select    = lane_reg;
    assign o_host_interrupt = interrupt_reg;

endmodule : hbd_host_port

// File: src/hbd_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and carriers for the host bus handshake and decode block
// ----------------------------------------------------------------------------
package hbd_pkg;

    // ------------------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS    = 10;
    localparam int LOCAL_BUS_CLOCK_MAX_KHZ       = 50000;
    localparam int LOCAL_BUS_CLOCK_EISA_MAX_KHZ  = 8330;
    // Wait time inserted on an asynchronous cycle when zero-wait is off
    localparam int ASYNC_WAIT_NS      = 40;
    localparam int ASYNC_WAIT_CYCLES  = (ASYNC_WAIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int WAIT_CNT_WIDTH     = 4;
    localparam logic [3:0] WAIT_CNT_LAST = 4'(ASYNC_WAIT_CYCLES - 1);

    // ------------------------------------------------------------------------
    // Data path and decode
    // ------------------------------------------------------------------------
    localparam int DATA_WIDTH         = 32;
    localparam int FIFO_DEPTH         = 4;
    localparam int ADDR_WIDTH         = 12;
    localparam int BASE_WIDTH         = 8;
    localparam logic [3:0] BASE_LOW_NIBBLE = 4'h0;
    localparam logic [3:0] FULL_LANES      = 4'hF;
    localparam logic [3:0] NO_LANES        = 4'h0;

    // ------------------------------------------------------------------------
    // Host pins as seen after the two-stage synchroniser
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                  local_bus_clock;
        logic                  rd_n;
        logic                  wr_n;
        logic                  dps_n;
        logic                  aq;
        logic                  vl_n;
        logic                  wnr;
        logic                  rtn_n;
        logic [3:0]            be_n;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
    } hbd_pins_type;

    // Idle bus: clock parked high, strobes and selects released
    localparam hbd_pins_type PINS_RESET = '{
        local_bus_clock  : 1'b1,
        rd_n  : 1'b1,
        wr_n  : 1'b1,
        dps_n : 1'b1,
        aq    : 1'b1,
        vl_n  : 1'b1,
        wnr   : 1'b0,
        rtn_n : 1'b1,
        be_n  : 4'hF,
        addr  : 12'h000,
        data  : 32'h0000_0000
    };

    typedef enum {A_IDLE, A_HOLD, A_DONE} hbd_async_state_type;
    typedef enum {S_IDLE, S_ACCESS, S_DONE} hbd_sync_state_type;

endpackage : hbd_pkg

// File: verification/hbd_host_port_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the host bus handshake block
// ----------------------------------------------------------------------------
module hbd_host_port_properties
    import hbd_pkg::*;
(
    input wire logic                  i_clock,
    input wire logic                  i_rst,
    input wire logic                  i_local_bus_clock,
    input wire logic                  i_read_strobe_n,
    input wire logic                  i_write_strobe_n,
    input wire logic                  i_data_path_select_n,
    input wire logic                  i_address_qualifier,
    input wire logic                  i_vl_mode_select_n,
    input wire logic [ADDR_WIDTH-1:0] i_upper_address_lines,
    input wire logic [BASE_WIDTH-1:0] i_base_high,
    input wire logic                  i_zero_wait,
    input wire logic                  i_status_pending,
    input wire logic                  o_async_ready_od_o,
    input wire logic                  o_async_ready_od_oe,
    input wire logic                  o_sync_ready_n,
    input wire logic                  o_local_device_hit_n
    ,input wire logic                 o_host_interrupt
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    chk_drain_only: assert property (o_async_ready_od_o == 1'b0)
        else $error("async ready drives high");
    chk_wait_states: assert property ($rose(o_async_ready_od_oe) && !i_zero_wait |-> o_async_ready_od_oe[*3])
        else $error("wait state too short");
    chk_start_cause: assert property ($rose(o_async_ready_od_oe) |->
        $past(!i_read_strobe_n || !i_write_strobe_n, 2) && $past(!o_local_device_hit_n || !i_data_path_select_n, 2))
        else $error("wait without a selected strobe");
    chk_decode_hit: assert property (o_local_device_hit_n ==
        !(!i_address_qualifier && i_upper_address_lines == {i_base_high, BASE_LOW_NIBBLE}))
        else $error("local device decode wrong");
    chk_irq_rise: assert property ($rose(i_status_pending) |=> o_host_interrupt)
        else $error("interrupt not raised");
    chk_irq_fall: assert property ($fell(i_status_pending) |=> !o_host_interrupt)
        else $error("interrupt not dropped");
    chk_sync_pulse: assert property ($fell(o_sync_ready_n) |-> !o_sync_ready_n[*6] ##[1:4] o_sync_ready_n)
        else $error("sync ready pulse length wrong");
    chk_parked_stable: assert property (i_local_bus_clock[*6] |-> $stable(o_sync_ready_n))
        else $error("sync ready moved without local clock");
    chk_burst_quiet: assert property (i_vl_mode_select_n[*8] |-> o_sync_ready_n)
        else $error("sync ready driven in burst mode");
endmodule : hbd_host_port_properties

bind hbd_host_port hbd_host_port_properties u_hbd_host_port_properties (.*);

// File: verification/hbd_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host side: local bus clock and ready-return
// ----------------------------------------------------------------------------
module hbd_host_model (
    input  wire logic i_run,
    input  wire logic i_burst,
    input  wire logic i_stall,
    output logic      o_local_bus_clock,
    output logic      o_ready_return_n
);
    // Taken at a rise so it never moves next to the sampling fall
    always @(posedge o_local_bus_clock) o_ready_return_n <= !i_stall;
    initial begin
        o_local_bus_clock = 1'b1;
        o_ready_return_n = 1'b1;
        #3;
        forever begin
            if (i_run) begin
                #(i_burst ? 80 : 40) o_local_bus_clock = 1'b0;
                #(i_burst ? 80 : 40) o_local_bus_clock = 1'b1;
            end else begin
                @(i_run);
            end
        end
    end
endmodule : hbd_host_model

// File: verification/hbd_host_port_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------------
module hbd_host_port_tb;
    import hbd_pkg::*;
    logic        i_clock = 1'b0, i_rst = 1'b1, i_read_strobe_n = 1'b1, i_write_strobe_n = 1'b1;
    logic        i_data_path_select_n = 1'b1, i_address_qualifier = 1'b1, i_vl_mode_select_n = 1'b1;
    logic        i_write_not_read = 1'b0, i_zero_wait = 1'b0, i_status_pending = 1'b1;
    logic        i_rx_valid = 1'b0, i_tx_ready = 1'b0, run = 1'b0, burst = 1'b0, stall = 1'b0;
    logic        i_local_bus_clock, i_ready_return_n, o_data_oe, o_async_ready_od_o, o_async_ready_od_oe;
    logic        o_sync_ready_n, o_local_device_hit_n, o_host_interrupt, o_rx_ready, o_tx_valid;
    logic [3:0]  i_byte_lane_enable_n = 4'hF, o_lane_select;
    logic [11:0] i_upper_address_lines = 12'h000;
    logic [7:0]  i_base_high = 8'hA5;
    logic [31:0] i_data = 32'h0, i_rx_data = 32'h0, o_data, o_tx_data;
    int          failures = 0, checks_done = 0, cycles = 0;

    hbd_host_port u_hbd_host_port (.*);
    hbd_host_model u_hbd_host_model (.i_run(run), .i_burst(burst), .i_stall(stall),
        .o_local_bus_clock(i_local_bus_clock), .o_ready_return_n(i_ready_return_n));

    always #5 i_clock = ~i_clock;

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic t_reset;
        repeat (10) @(negedge i_clock);
        check("oe", 0, o_async_ready_od_oe);
        check("srdy", 1, o_sync_ready_n);
        check("irq", 0, o_host_interrupt);
        check("rx ready", 1, o_rx_ready);
        i_status_pending = 1'b0;
        i_rst = 1'b0;
    endtask : t_reset

    task automatic t_decode;
        for (int i = 0; i < 4; i++) begin
            @(negedge i_clock);
            i_address_qualifier = i[0];
            i_upper_address_lines = i[1] ? 12'hA60 : 12'hA50;
            #1 check("hit", 32'(i != 0), o_local_device_hit_n);
        end
        i_address_qualifier = 1'b1;
    endtask : t_decode

    task automatic t_irq;
        @(negedge i_clock) i_status_pending = 1'b1;
        @(negedge i_clock) check("irq", 1, o_host_interrupt);
        i_status_pending = 1'b0;
        @(negedge i_clock) check("irq", 0, o_host_interrupt);
    endtask : t_irq

    // Empty read FIFO first, so the wait is seen before the word arrives
    task automatic t_async_read;
        int n;
        @(negedge i_clock);
        i_data_path_select_n = 1'b0;
        i_read_strobe_n = 1'b0;
        repeat (12) @(negedge i_clock);
        check("oe", 1, o_async_ready_od_oe);
        check("data oe", 1, o_data_oe);
        i_rx_data = 32'h5A5A_0001;
        i_rx_valid = 1'b1;
        @(negedge i_clock) i_rx_valid = 1'b0;
        for (n = 0; n < 20 && o_async_ready_od_oe !== 1'b0; n++) @(negedge i_clock);
        check("oe", 0, o_async_ready_od_oe);
        i_read_strobe_n = 1'b1;
        i_data_path_select_n = 1'b1;
        repeat (4) @(negedge i_clock);
        check("data", 32'h5A5A_0001, o_data);
    endtask : t_async_read

    task automatic t_async_write;
        int n;
        logic seen;
        seen = 1'b0;
        i_zero_wait = 1'b1;
        i_data_path_select_n = 1'b0;
        for (int i = 1; i <= 5; i++) begin
            @(negedge i_clock);
            i_data = 32'h3C00_0000 + 32'(i);
            i_write_strobe_n = 1'b0;
            repeat (8) @(negedge i_clock) if (i < 5) seen |= o_async_ready_od_oe;
            if (i == 5) check("oe", 1, o_async_ready_od_oe);
            else i_write_strobe_n = 1'b1;
            repeat (3) @(negedge i_clock);
        end
        check("zero wait", 0, seen);
        i_tx_ready = 1'b1;
        for (int k = 1; k <= 5; k++) begin
            for (n = 0; n < 20 && o_tx_valid !== 1'b1; n++) @(negedge i_clock);
            check("tx", 32'h3C00_0000 + 32'(k), o_tx_data);
            @(negedge i_clock);
        end
        i_write_strobe_n = 1'b1;
        i_data_path_select_n = 1'b1;
        @(negedge i_clock) check("empty", 0, o_tx_valid);
        i_tx_ready = 1'b0;
    endtask : t_async_write

    task automatic t_sync_vl;
        int n;
        @(negedge i_clock);
        i_vl_mode_select_n = 1'b0;
        i_write_not_read = 1'b1;
        i_byte_lane_enable_n = 4'h5;
        i_data = 32'h0F0F_00A1;
        i_data_path_select_n = 1'b0;
        run = 1'b1;
        for (n = 0; n < 300 && o_sync_ready_n !== 1'b0; n++) @(negedge i_clock);
        check("srdy", 0, o_sync_ready_n);
        i_data_path_select_n = 1'b1;
        for (n = 0; n < 40 && o_sync_ready_n !== 1'b1; n++) @(negedge i_clock);
        run = 1'b0;
        check("tx", 32'h0F0F_00A1, o_tx_data);
        check("lanes", FULL_LANES, o_lane_select);
        i_tx_ready = 1'b1;
        @(negedge i_clock) i_tx_ready = 1'b0;
        repeat (20) @(negedge i_clock);
        i_vl_mode_select_n = 1'b1;
    endtask : t_sync_vl

    task automatic t_sync_burst;
        int n;
        @(negedge i_clock);
        burst = 1'b1;
        stall = 1'b1;
        i_write_not_read = 1'b0;
        i_rx_data = 32'h9696_00B2;
        i_rx_valid = 1'b1;
        @(negedge i_clock) i_rx_valid = 1'b0;
        i_data_path_select_n = 1'b0;
        run = 1'b1;
        repeat (80) @(negedge i_clock);
        check("held", 32'h5A5A_0001, o_data);
        stall = 1'b0;
        for (n = 0; n < 300 && o_data !== 32'h9696_00B2; n++) @(negedge i_clock);
        check("data", 32'h9696_00B2, o_data);
        i_data_path_select_n = 1'b1;
        repeat (40) @(negedge i_clock);
        run = 1'b0;
        check("srdy", 1, o_sync_ready_n);
    endtask : t_sync_burst

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        t_reset();
        t_decode();
        t_irq();
        t_async_read();
        t_async_write();
        t_sync_vl();
        t_sync_burst();
        final_report();
    end
endmodule : hbd_host_port_tb
